// [verilog/bgp_bridge_gate_protection.sv]
// Gate sequencing, bridge disable, short and open-load diagnostics.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "bgp_consts.svh"

// Overview of operation
// R1: Random off-time dither when enable bit set.
// R2: Low-side select: 00/01 min, 10 med, 11 max.
// R3: High-side select: min, min+TC, med+TC, max.
// R4: Turn on only after opposite gate discharged.
// R5: Hardware disable input high forces all off.
// R6: Off-time zero acts as software disable.
// R7: Outside holds disable low when unused.
// R8: Short: bridge off, chopper aborted, count up.
// R9: Polarity change decrements the short counter.
// R10: Count three latches MOSFETs off until disable.
// R11: Per-coil short flag, cleared when disabled.
// R12: High-side coil voltage checked at delay expiry.
// R13: Detection disable bit suppresses short detection.
// R14: Delay select 3.2, 1.6, 1.2, 0.8 us.
// R15: Outside picks delay longer than slope time.
// R16: Open-load set if no chopper event in period.
// R17: Open-load held while current below 1/16.
// R18: Open-load re-evaluated at each polarity toggle.
// R19: Open-load is status only, no action.
// R20: Per-coil counters cleared whenever bridges disabled.
module bgp_bridge_gate_protection #(
  parameter int CUR_W = 5
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           regAddr,
  input  wire logic [15:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic [15:0]               regRdata,
  input  wire logic                 bridgeDisableN,
  input  wire logic [3:0]           lsGateDischarged,
  input  wire logic [3:0]           hsGateDischarged,
  input  wire logic [3:0]           coilAtSupply,
  input  wire logic [3:0]           wantHigh,
  input  wire logic [3:0]           wantLow,
  input  wire logic [1:0]           coilPolarity,
  input  wire logic [1:0]           chopperEvent,
  input  wire logic [1:0][CUR_W-1:0] coilCurrent,
  output bgp_pkg::bgp_gate_t        gate,
  output bgp_pkg::bgp_drive_t       lsDrive,
  output bgp_pkg::bgp_drive_t       hsDrive,
  output logic                      hsTempComp,
  output logic [5:0]                offTimeEff,
  output logic [1:0]                chopperAbort
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Detection delay in clock cycles for a delay select code.
  function automatic logic [8:0] s2gCycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: s2gCycles = 9'(`BGP_NS2CYC(`BGP_S2G_DLY0_NS));
      2'h1: s2gCycles = 9'(`BGP_NS2CYC(`BGP_S2G_DLY1_NS));
      2'h2: s2gCycles = 9'(`BGP_NS2CYC(`BGP_S2G_DLY2_NS));
      2'h3: s2gCycles = 9'(`BGP_NS2CYC(`BGP_S2G_DLY3_NS));
    endcase
  endfunction

  // Current at or above the open-load threshold of the full scale.
  function automatic logic curHighEnough(input logic [CUR_W-1:0] cur);
    curHighEnough = ({cur, 4'h0} >= (CUR_W + 4)'({CUR_W{1'b1}}));
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [12:0] pinMeta_ff;
  logic [12:0] pinSync_ff;
  logic        disPin;
  logic [3:0]  lsDisS;
  logic [3:0]  hsDisS;
  logic [3:0]  atSupplyS;

  // Two stages on every pin; only the second stage is read.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinMeta_ff <= 13'h0000;
      pinSync_ff <= 13'h0000;
    end else begin
      pinMeta_ff <= {bridgeDisableN, lsGateDischarged,
                     hsGateDischarged, coilAtSupply};
      pinSync_ff <= pinMeta_ff;
    end
  end

  assign disPin    = pinSync_ff[12];
  assign lsDisS    = pinSync_ff[11:8];
  assign hsDisS    = pinSync_ff[7:4];
  assign atSupplyS = pinSync_ff[3:0];

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  bgp_pkg::bgp_ctrl_t ctrl_ff;
  bgp_pkg::bgp_ctrl_t nxt_ctrl;
  logic [15:0]         rdata_ff;
  logic [15:0]         nxt_rdata;
  bgp_pkg::bgp_drive_t lsDrv_ff;
  bgp_pkg::bgp_drive_t hsDrv_ff;
  bgp_pkg::bgp_drive_t nxt_lsDrv;
  bgp_pkg::bgp_drive_t nxt_hsDrv;
  logic                hsTc_ff;
  logic                nxt_hsTc;
  logic [1:0][1:0]     cnt_ff;
  logic [1:0]          ol_ff;
  logic [1:0]          shortLatched;
  logic                off;

  // Writes land in one cycle; reads answer in the next and only there.
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_rdata = 16'h0000;
    if (regWr && regAddr == `BGP_ADDR_CTRL) begin
      nxt_ctrl = bgp_pkg::bgp_ctrl_t'(regWdata[`BGP_CTRL_W-1:0]);
    end
    if (regRd) begin
      unique case (regAddr)
        `BGP_ADDR_CTRL:   nxt_rdata = {4'h0, ctrl_ff};
        `BGP_ADDR_STATUS: nxt_rdata = {7'h00, off, cnt_ff[1], cnt_ff[0],
                                       ol_ff, shortLatched};
        default:          nxt_rdata = 16'h0000;
      endcase
    end
    // Slope selects map to drive levels; two low codes share minimum.
    unique case (ctrl_ff.lsSel) // R2
      2'h2:    nxt_lsDrv = bgp_pkg::BGP_DRV_MED;
      2'h3:    nxt_lsDrv = bgp_pkg::BGP_DRV_MAX;
      default: nxt_lsDrv = bgp_pkg::BGP_DRV_MIN;
    endcase
    unique case (ctrl_ff.hsSel) // R3
      2'h2:    nxt_hsDrv = bgp_pkg::BGP_DRV_MED;
      2'h3:    nxt_hsDrv = bgp_pkg::BGP_DRV_MAX;
      default: nxt_hsDrv = bgp_pkg::BGP_DRV_MIN;
    endcase
    nxt_hsTc = (ctrl_ff.hsSel == 2'h1) || (ctrl_ff.hsSel == 2'h2); // R3
  end

  // Off time resets to zero, so the bridges wake up disabled.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_ff  <= bgp_pkg::bgp_ctrl_t'(`BGP_CTRL_RST);
      rdata_ff <= 16'h0000;
      lsDrv_ff <= bgp_pkg::BGP_DRV_MIN;
      hsDrv_ff <= bgp_pkg::BGP_DRV_MIN;
      hsTc_ff  <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      lsDrv_ff <= nxt_lsDrv;
      hsDrv_ff <= nxt_hsDrv;
      hsTc_ff  <= nxt_hsTc;
    end
  end

  assign regRdata   = rdata_ff;
  assign lsDrive    = lsDrv_ff;
  assign hsDrive    = hsDrv_ff;
  assign hsTempComp = hsTc_ff;

  // ----------------------------------------------------------------------
  // Bridge control and diagnostics
  // ----------------------------------------------------------------------
  bgp_pkg::bgp_gate_t gate_ff;
  bgp_pkg::bgp_gate_t nxt_gate;
  logic [3:0][8:0]    dly_ff;
  logic [3:0][8:0]    nxt_dly;
  logic [1:0][1:0]    nxt_cnt;
  logic [1:0]         blk_ff;
  logic [1:0]         nxt_blk;
  logic [1:0]         seen_ff;
  logic [1:0]         nxt_seen;
  logic [1:0]         nxt_ol;
  logic [1:0]         pol_ff;
  logic [1:0]         polTog;
  logic [3:0]         shortEvt;
  logic [1:0]         coilShort;
  logic [1:0]         abort_ff;
  logic [15:0]        lfsr_ff;
  logic [15:0]        nxt_lfsr;
  logic [5:0]         offEff_ff;
  logic [5:0]         nxt_offEff;
  logic [8:0]         dlyLim;
  logic               allOff;

  // Disable sources; a latched short keeps every MOSFET off.
  assign off    = disPin || (ctrl_ff.offTime == 4'h0); // R5 R6
  assign allOff = off || (|shortLatched); // R10
  assign dlyLim = s2gCycles(ctrl_ff.s2gDelay); // R14

  always_comb begin
    nxt_gate   = '0;
    nxt_dly    = dly_ff;
    nxt_cnt    = cnt_ff;
    nxt_blk    = blk_ff;
    nxt_seen   = seen_ff;
    nxt_ol     = ol_ff;
    shortEvt   = 4'h0;
    coilShort  = 2'h0;
    polTog     = coilPolarity ^ pol_ff;
    // Galois LFSR runs freely; its low bits dither the off time.
    nxt_lfsr   = {1'b0, lfsr_ff[15:1]} ^
                 (lfsr_ff[0] ? `BGP_LFSR_TAPS : 16'h0000);
    nxt_offEff = offEff_ff;
    if (|chopperEvent) begin
      nxt_offEff = {2'h0, ctrl_ff.offTime} +
                   {4'h0, (ctrl_ff.rndEnable ? lfsr_ff[1:0] : 2'h0)}; // R1
    end
    // The coil voltage is judged once, when the delay has just run out.
    for (int h = 0; h < 4; h++) begin
      shortEvt[h] = !ctrl_ff.s2gDisable && gate_ff.hs[h] &&
                    (dly_ff[h] == dlyLim - 9'h001) && !atSupplyS[h]; // R12 R13
      if (!gate_ff.hs[h]) begin
        nxt_dly[h] = 9'h000;
      end else if (dly_ff[h] != dlyLim) begin
        nxt_dly[h] = dly_ff[h] + 9'h001;
      end
    end
    for (int c = 0; c < 2; c++) begin
      coilShort[c] = shortEvt[2*c] || shortEvt[2*c+1];
      // The aborted bridge stays off until the chopper drops its high-side
      // request or the polarity changes. Releasing it per chopper cycle is
      // what lets a persistent short be counted up to the latch level.
      nxt_blk[c] = !off && (coilShort[c] ||
                   (blk_ff[c] && !polTog[c] && |wantHigh[2*c +: 2])); // R8
      if (off) begin
        nxt_cnt[c] = 2'h0; // R20
      end else if (cnt_ff[c] == `BGP_SHORT_LIMIT) begin
        nxt_cnt[c] = cnt_ff[c]; // R10
      end else if (coilShort[c] && !polTog[c]) begin
        nxt_cnt[c] = cnt_ff[c] + 2'h1; // R8
      end else if (polTog[c] && !coilShort[c] && cnt_ff[c] != 2'h0) begin
        nxt_cnt[c] = cnt_ff[c] - 2'h1; // R9
      end
      // Open-load is only reported; nothing else looks at it.
      if (polTog[c] && curHighEnough(coilCurrent[c])) begin // R17 R18
        nxt_ol[c] = !(seen_ff[c] || chopperEvent[c]); // R16 R19
      end
      nxt_seen[c] = !polTog[c] && (seen_ff[c] || chopperEvent[c]);
    end
    // A side turns on only when the opposite gate reads discharged.
    for (int h = 0; h < 4; h++) begin
      nxt_gate.hs[h] = !allOff && !blk_ff[h/2] && !coilShort[h/2] &&
                       wantHigh[h] && !wantLow[h] &&
                       lsDisS[h] && !gate_ff.ls[h]; // R4 R8
      nxt_gate.ls[h] = !allOff && !blk_ff[h/2] && !coilShort[h/2] &&
                       wantLow[h] && !wantHigh[h] &&
                       hsDisS[h] && !gate_ff.hs[h]; // R4
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gate_ff   <= '0;
      dly_ff    <= '0;
      cnt_ff    <= '0;
      blk_ff    <= 2'h0;
      seen_ff   <= 2'h0;
      ol_ff     <= 2'h0;
      pol_ff    <= 2'h0;
      abort_ff  <= 2'h0;
      lfsr_ff   <= `BGP_LFSR_SEED;
      offEff_ff <= 6'h00;
    end else begin
      gate_ff   <= nxt_gate;
      dly_ff    <= nxt_dly;
      cnt_ff    <= nxt_cnt;
      blk_ff    <= nxt_blk;
      seen_ff   <= nxt_seen;
      ol_ff     <= nxt_ol;
      pol_ff    <= coilPolarity;
      abort_ff  <= coilShort; // R8
      lfsr_ff   <= nxt_lfsr;
      offEff_ff <= nxt_offEff;
    end
  end

  // Flags are cleared together with the counters on any disable.
  assign shortLatched[0] = (cnt_ff[0] == `BGP_SHORT_LIMIT); // R11
  assign shortLatched[1] = (cnt_ff[1] == `BGP_SHORT_LIMIT); // R11
  assign gate            = gate_ff;
  assign chopperAbort    = abort_ff;
  assign offTimeEff      = offEff_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_hw_disable: assert property (disPin |=> gate_ff == '0) // R5
    else $error("Gates on while hardware disable active.");
  chk_sw_disable: assert property ( // R6
    (ctrl_ff.offTime == 4'h0) |=> gate_ff == '0)
    else $error("Gates on while off time is zero.");
  chk_no_cross: assert property ((gate_ff.hs & gate_ff.ls) == 4'h0) // R4
    else $error("Both sides of a half-bridge on.");
  chk_bbm_wait: assert property ( // R4
    ((gate_ff.hs & ~$past(gate_ff.hs) & ~$past(lsDisS)) == 4'h0))
    else $error("High side on before low gate discharged.");
  chk_short_act: assert property ( // R8
    coilShort[0] |=> chopperAbort[0] && gate_ff.hs[1:0] == 2'h0)
    else $error("Short on coil A not acted on.");
  chk_short_latch: assert property ( // R10
    (|shortLatched) && !off |=> (|shortLatched) ##1 gate_ff == '0)
    else $error("Latched short did not hold bridges off.");
  chk_flag_clear: assert property (off |=> shortLatched == 2'h0) // R11
    else $error("Short flag survived disable.");
  chk_detect_off: assert property ( // R13
    ctrl_ff.s2gDisable |-> shortEvt == 4'h0)
    else $error("Short detected while detection disabled.");
  chk_ol_hold: assert property ( // R17
    !polTog[0] || !curHighEnough(coilCurrent[0]) |=> $stable(ol_ff[0]))
    else $error("Open-load A changed without qualified toggle.");
  chk_rnd_plain: assert property ( // R1
    !ctrl_ff.rndEnable && chopperEvent[1] |=>
      offTimeEff == {2'h0, $past(ctrl_ff.offTime)})
    else $error("Off time modulated while dither disabled.");

endmodule
`default_nettype wire

// [verilog/bgp_consts.svh]
// Constants of the bridge gate protection block: offsets, resets, timings.
`ifndef BGP_CONSTS_SVH
`define BGP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses) and reset values
// ----------------------------------------------------------------------
`define BGP_ADDR_CTRL   8'h00
`define BGP_ADDR_STATUS 8'h04
`define BGP_CTRL_RST    12'h000
`define BGP_CTRL_W      12

// ----------------------------------------------------------------------
// Timing: clock rate and short detection delays in nanoseconds
// ----------------------------------------------------------------------
`define BGP_CLK_MHZ     100
`define BGP_S2G_DLY0_NS 3200
`define BGP_S2G_DLY1_NS 1600
`define BGP_S2G_DLY2_NS 1200
`define BGP_S2G_DLY3_NS 800
`define BGP_NS2CYC(ns)  (((ns) * `BGP_CLK_MHZ) / 1000)

// ----------------------------------------------------------------------
// Protection and diagnostics figures
// ----------------------------------------------------------------------
`define BGP_SHORT_LIMIT 2'h3
`define BGP_OL_DIVISOR  16
`define BGP_LFSR_SEED   16'hace1
`define BGP_LFSR_TAPS   16'hb400

`endif

// [verilog/bgp_pkg.sv]
// Types shared by the bridge gate protection block.
`default_nettype none
package bgp_pkg;

  // Control register fields, most significant first.
  typedef struct packed {
    logic [3:0] offTime;
    logic [1:0] s2gDelay;
    logic       s2gDisable;
    logic [1:0] hsSel;
    logic [1:0] lsSel;
    logic       rndEnable;
  } bgp_ctrl_t;

  // Gate driver strength handed to the analog drivers.
  typedef enum logic [1:0] {
    BGP_DRV_MIN = 2'h0,
    BGP_DRV_MED = 2'h1,
    BGP_DRV_MAX = 2'h2
  } bgp_drive_t;

  // Gate commands, one bit per half-bridge (0,1 coil A; 2,3 coil B).
  typedef struct packed {
    logic [3:0] hs;
    logic [3:0] ls;
  } bgp_gate_t;

endpackage
`default_nettype wire

// [bench/bgp_bridge_model.sv]
// Behavioural model of the external MOSFET bridges and the coil outputs.
`timescale 1ns/10ps
`default_nettype none
module bgp_bridge_model (
  input  wire logic               sys_clk,
  input  wire bgp_pkg::bgp_gate_t gate,
  input  wire logic [7:0]         slope,
  input  wire logic [3:0]         shorted,
  output logic [3:0]              lsDis,
  output logic [3:0]              hsDis,
  output logic [3:0]              atSupply
);
  logic [7:0] lsCnt [4] = '{8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] hsCnt [4] = '{8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] onCnt [4] = '{8'h00, 8'h00, 8'h00, 8'h00};

  // A gate drains only slope cycles after its command drops, so a slow
  // slope exposes a bridge that switches before the opposite side is off.
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      lsCnt[i] <= gate.ls[i] ? 8'h00 : lsCnt[i] + {7'h00, lsCnt[i] != 8'hff};
      hsCnt[i] <= gate.hs[i] ? 8'h00 : hsCnt[i] + {7'h00, hsCnt[i] != 8'hff};
      onCnt[i] <= !gate.hs[i] ? 8'h00 : onCnt[i] + {7'h00, onCnt[i] != 8'hff};
    end
  end

  // A shorted output never climbs to the detection level.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lsDis[i] = lsCnt[i] >= slope;
      hsDis[i] = hsCnt[i] >= slope;
      atSupply[i] = gate.hs[i] && onCnt[i] >= slope && !shorted[i];
    end
  end
endmodule
`default_nettype wire

// [bench/tb_bgp_bridge_gate_protection.sv]
// Self-checking testbench of the bridge gate protection block.
`timescale 1ns/10ps
`default_nettype none
module tb_bgp_bridge_gate_protection;
  logic sys_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic bridgeDisableN = 1'b0;
  logic [7:0] regAddr = 8'h00, slope = 8'h02;
  logic [15:0] regWdata = 16'h0000, regRdata, rv;
  logic [3:0] wantHigh = 4'h0, wantLow = 4'h0, shorted = 4'h0;
  logic [3:0] lsDis, hsDis, atSup;
  logic [1:0] coilPolarity = 2'h0, chopperEvent = 2'h0, chopperAbort;
  logic [1:0][4:0] coilCurrent = '0;
  logic [5:0] offTimeEff;
  logic hsTempComp;
  bgp_pkg::bgp_gate_t gate;
  bgp_pkg::bgp_drive_t lsDrive, hsDrive;
  int num_errors = 0;
  int compares = 0;

  bgp_bridge_gate_protection uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .bridgeDisableN(bridgeDisableN),
    .lsGateDischarged(lsDis), .hsGateDischarged(hsDis),
    .coilAtSupply(atSup), .wantHigh(wantHigh), .wantLow(wantLow),
    .coilPolarity(coilPolarity), .chopperEvent(chopperEvent),
    .coilCurrent(coilCurrent), .gate(gate), .lsDrive(lsDrive),
    .hsDrive(hsDrive), .hsTempComp(hsTempComp), .offTimeEff(offTimeEff),
    .chopperAbort(chopperAbort));
  bgp_bridge_model model (.sys_clk(sys_clk), .gate(gate), .slope(slope),
    .shorted(shorted), .lsDis(lsDis), .hsDis(hsDis), .atSupply(atSup));

  // The 100 MHz clock.
  always #5 sys_clk = ~sys_clk;

  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Outputs are registered, so values sampled at an edge are settled ones.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= 8'h00;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);
    d = regRdata;
  endtask

  function automatic logic [15:0] ctrl(input logic [2:0] off,
    input logic [1:0] dly, input logic dis, input logic [1:0] s, input logic r);
    return {5'h00, off, dly, dis, s, s, r};
  endfunction

  task automatic toggle(input int c);
    @(posedge sys_clk);
    coilPolarity[c] <= ~coilPolarity[c];
    tick(5);
  endtask

  // Every slope code reaches both drivers; hold-off and disables follow.
  task automatic t_gates;
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(ctrl(3'h4, 2'h0, 1'b1, s[1:0], 1'b0));
      tick(3);
      chk("lsDrive", s < 2 ? 16'h0000 : 16'(s - 1), 16'(lsDrive));
      chk("hsDrive", s < 3 ? 16'(s / 2) : 16'h0002, 16'(hsDrive));
      chk("hsTempComp", 16'(s == 1 || s == 2), 16'(hsTempComp));
    end
    slope <= 8'h14;
    @(posedge sys_clk) wantLow <= 4'h1;
    tick(40);
    wantLow <= 4'h0;
    wantHigh <= 4'h1;
    n = 0;
    while (gate.hs[0] !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("holdoff", 16'h0001, 16'(n >= 20 && n <= 28));
    bridgeDisableN <= 1'b1;
    tick(5);
    chk("gate hw", 16'h0000, 16'(gate));
    bridgeDisableN <= 1'b0;
    wr(ctrl(3'h0, 2'h0, 1'b1, 2'h0, 1'b0));
    tick(3);
    chk("gate sw", 16'h0000, 16'(gate));
    rd(8'h04, rv);
    chk("disabled", 16'h0001, 16'(rv[8]));
    @(posedge sys_clk) wantHigh <= 4'h0;
    slope <= 8'h02;
  endtask

  // A shorted high side is cut after the selected delay.
  task automatic t_short(input logic [1:0] dly, input logic dis);
    int n, lim;
    lim = dly == 0 ? 320 : dly == 1 ? 160 : dly == 2 ? 120 : 80;
    wr(ctrl(3'h4, dly, dis, 2'h0, 1'b0));
    @(posedge sys_clk) wantHigh <= 4'h1;
    shorted <= 4'h1;
    n = 0;
    while (gate.hs[0] !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    n = 0;
    while (chopperAbort[0] !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (dis) begin
      chk("no abort", 16'h0001, 16'(n == 400 && gate.hs[0] === 1'b1));
    end else begin
      chk("delay", 16'h0001, 16'(n >= lim - 2 && n <= lim + 2));
      tick(3);
      chk("coil A off", 16'h0000, 16'(gate.hs[1:0]));
    end
    rd(8'h04, rv);
    chk("count A", 16'(!dis), 16'(rv[5:4]));
    @(posedge sys_clk) wantHigh <= 4'h0;
    toggle(0);
    rd(8'h04, rv);
    chk("count A", 16'h0000, 16'(rv[5:4]));
  endtask

  // Three shorts in separate chopper cycles latch the bridge off until a
  // disable; the disable clears flag and counter.
  task automatic t_latch;
    int n;
    wr(ctrl(3'h4, 2'h3, 1'b0, 2'h0, 1'b0));
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk) wantHigh <= 4'h1;
      n = 0;
      while (chopperAbort[0] !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      chk("abort", 16'h0001, 16'(n < 200));
      @(posedge sys_clk) wantHigh <= 4'h0;
      tick(3);
    end
    rd(8'h04, rv);
    chk("latched", 16'h0031, 16'(rv[5:0] & 6'h33));
    @(posedge sys_clk) wantHigh <= 4'h1;
    tick(10);
    chk("latch gate", 16'h0000, 16'(gate));
    toggle(0);
    rd(8'h04, rv);
    chk("latch hold", 16'h0003, 16'(rv[5:4]));
    wr(ctrl(3'h0, 2'h3, 1'b0, 2'h0, 1'b0));
    tick(2);
    rd(8'h04, rv);
    chk("cleared", 16'h0100, rv & 16'h0133);
    wr(ctrl(3'h4, 2'h3, 1'b1, 2'h0, 1'b0));
    tick(5);
    chk("re-enable", 16'h0001, 16'(gate.hs[0]));
    @(posedge sys_clk) wantHigh <= 4'h0;
  endtask

  // Open-load flag follows chopper activity between polarity toggles.
  task automatic t_open;
    coilCurrent[0] <= 5'h05;
    toggle(0);
    rd(8'h04, rv);
    chk("open A", 16'h0001, 16'(rv[2]));
    @(posedge sys_clk) chopperEvent <= 2'h1;
    @(posedge sys_clk) chopperEvent <= 2'h0;
    toggle(0);
    rd(8'h04, rv);
    chk("open A", 16'h0000, 16'(rv[2]));
    coilCurrent[0] <= 5'h01;
    toggle(0);
    rd(8'h04, rv);
    chk("open A", 16'h0000, 16'(rv[2]));
  endtask

  // The off time is plain without dither and spread with it.
  task automatic t_random(input logic r);
    logic moved;
    moved = 1'b0;
    wr(ctrl(3'h4, 2'h0, 1'b1, 2'h0, r));
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk) chopperEvent <= 2'h2;
      @(posedge sys_clk) chopperEvent <= 2'h0;
      tick(3);
      moved |= offTimeEff != 6'h04;
      chk("off range", 16'h0001,
          16'(offTimeEff >= 4 && offTimeEff <= 4 + 3 * r));
    end
    chk("dither", 16'(r), 16'(moved));
  endtask

  // Main sequence.
  initial begin
    tick(20);
    rst_n <= 1'b1;
    tick(1);
    chk("gate rst", 16'h0000, 16'(gate));
    rd(8'h04, rv);
    chk("status rst", 16'h0100, rv);
    rd(8'h08, rv);
    chk("unmapped", 16'h0000, rv);
    t_gates();
    for (int d = 0; d < 4; d++)
      t_short(d[1:0], 1'b0);
    t_short(2'h3, 1'b1);
    t_latch();
    t_open();
    t_random(1'b0);
    t_random(1'b1);
    end_sim();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    tick(30000);
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
